/* rtl/sscr_map.svh */
// offsets, field positions, characters and timing counts of the command responder
`ifndef SSCR_MAP_SVH
`define SSCR_MAP_SVH
`define SSCR_CLK_NS     8
`define SSCR_TENTH_NS   100000000
`define SSCR_TENTH_CYC  (`SSCR_TENTH_NS / `SSCR_CLK_NS)
`define SSCR_A_CTRL     8'h00
`define SSCR_A_CFG      8'h04
`define SSCR_A_STAT     8'h08
`define SSCR_A_IRQ      8'h0c
`define SSCR_A_MASK     8'h10
`define SSCR_CTRL_RST   32'h0000_0001
`define SSCR_CFG_RST    32'h0032_0000
`define SSCR_B_LAN      24
`define SSCR_B_PANEL    25
`define SSCR_B_LOOP     28
`define SSCR_MAX_ARGS   7'h40
`define SSCR_NPORT      6'h20
`define SSCR_CR         8'h0d
`define SSCR_SL         8'h2f
`define SSCR_CHR_LO     8'h7b
`define SSCR_CHR_HI     8'h5b
`define SSCR_C_P        8'h50
`define SSCR_C_R        8'h52
`define SSCR_C_S        8'h53
`define SSCR_C_T        8'h54
`define SSCR_C_U        8'h55
`define SSCR_C_W        8'h57
`define SSCR_C_X        8'h58
`define SSCR_C_A        8'h61
`define SSCR_C_H        8'h68
`define SSCR_C_TMP      8'h74
`define SSCR_C_ID       8'h3f
`endif

/* rtl/sscr_pkg.sv */
// types of the command responder
`default_nettype none
package sscr_pkg;
	typedef enum logic [2:0] {
		PS_IDLE = 3'b000,
		PS_S1   = 3'b001,
		PS_S2   = 3'b010,
		PS_DEV  = 3'b011,
		PS_CMD  = 3'b100,
		PS_ARG  = 3'b101,
		PS_SKIP = 3'b110
	} sscr_pst_e;
	typedef enum logic [2:0] {
		TS_IDLE = 3'b000,
		TS_HEAD = 3'b001,
		TS_BODY = 3'b010,
		TS_SCAN = 3'b011,
		TS_CR   = 3'b100
	} sscr_tst_e;
	typedef logic [31:0][5:0] sscr_map_t;
endpackage
`default_nettype wire

/* rtl/sscr_top.sv */
// serial command responder of the port patching switch
`timescale 1ns/1ps
`default_nettype none
`include "sscr_map.svh"
//Overview of operation
//- patch command takes up to sixteen pairs
//- assignment report lists pairs as characters
//- retrigger and switch-with-holdoff restart timer
//- unlock checks password, replies fail or ok
//- switch-without-holdoff zeroes timer at once
//- status bits0-2: supplies, over temperature
//- status bits3-7: lan, locks, recall, loopback
//- holdoff report two hex digits, tenths
//- temperature report signed degrees then cr
//- identification fields separated by spaces
//- revision report digit string then cr
//- numbers map to characters by table
//- former partner turned off or looped
module sscr_top #(
	parameter int unsigned          TENTH_CYC = `SSCR_TENTH_CYC,
	parameter int unsigned          REV_LEN   = 4,
	// arbitrary revision and identity strings
	parameter logic [8*REV_LEN-1:0] REV_STR   = "0100",
	parameter int unsigned          ID_LEN    = 24,
	parameter logic [8*ID_LEN-1:0]  ID_STR    = "PSW-32  0000001 01/01/00"
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// apb slave
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [7:0]   paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic [31:0]       prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	// received command bytes
	input  wire logic         rx_valid_i,
	input  wire logic [7:0]   rx_data_i,
	// reply bytes
	input  wire logic         tx_ready_i,
	output logic              tx_valid_o,
	output logic [7:0]        tx_data_o,
	// sensor pins
	input  wire logic         psu1_fail_i,
	input  wire logic         psu2_fail_i,
	input  wire logic [7:0]   temp_i,
	// active patching and interrupt
	output logic [191:0]      map_o,
	output logic              irq_o
);
	function automatic logic [7:0] port_chr(input logic [5:0] n);
		port_chr = (n <= 6'h04) ? `SSCR_CHR_LO + {2'b00, n} : `SSCR_CHR_HI + {2'b00, n};
	endfunction
	function automatic logic [7:0] hex_chr(input logic [3:0] v);
		hex_chr = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
	endfunction

	sscr_pkg::sscr_pst_e p_st_q;
	sscr_pkg::sscr_tst_e tx_st_q;
	sscr_pkg::sscr_map_t pend_q, pend_d, act_q;
	logic [31:0]  ctrl_q, cfg_q, prdata_q, pre_q;
	logic [4:0]   ist_q, mask_q, ap_n_q, ap_i_q, bidx_q, scan_q;
	logic [7:0]   cmd_q, rcmd_q, hold_q, stat_q, tx_q;
	logic [6:0]   acnt_q;
	logic [15:0]  aval_q;
	logic [3:0]   tens_q;
	logic [5:0]   pbuf_q [0:31];
	logic [1:0]   hidx_q;
	logic         aerr_q, exec_q, disc_q, ulk_q, half_q, txv_q, pready_q, perr_q, irq_q;
	logic         psu1_m, psu1_s, psu2_m, psu2_s;
	logic [7:0]   temp_m, temp_s, temp_p, temp_v;

	// pin synchronisers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{psu1_m, psu1_s, psu2_m, psu2_s} <= 4'h0;
			{temp_m, temp_s, temp_p, temp_v} <= 32'h0000_0000;
		end else begin
			{psu1_m, psu1_s, psu2_m, psu2_s} <= {psu1_fail_i, psu1_m, psu2_fail_i, psu2_m};
			{temp_m, temp_s, temp_p} <= {temp_i, temp_m, temp_s};
			if (temp_s == temp_p) temp_v <= temp_s; // word taken only once two samples agree
		end
	end

	// receive decode
	wire       rx_cr   = rx_valid_i && (rx_data_i == `SSCR_CR);
	wire       is_dig  = (rx_data_i >= 8'h30) && (rx_data_i <= 8'h39);
	wire [6:0] pv7     = {3'h0, tens_q} * 7'h0a + {3'h0, rx_data_i[3:0]};
	wire       pv_bad  = (pv7 == 7'h00) || (pv7 > 7'h20);
	wire [5:0] dev     = ctrl_q[5:0];
	wire       is_p    = cmd_q == `SSCR_C_P;
	wire       is_rt   = (cmd_q == `SSCR_C_T) || (cmd_q == `SSCR_C_W);
	wire       is_x    = cmd_q == `SSCR_C_X;
	wire       is_u    = cmd_q == `SSCR_C_U;
	wire       pw_ok   = !aerr_q && (acnt_q == 7'h04) && (aval_q == cfg_q[15:0]);
	wire       p_ok    = !aerr_q && (acnt_q >= 7'h04) && (acnt_q[1:0] == 2'b00);
	wire       rep_cmd = (cmd_q == `SSCR_C_R) || (cmd_q == `SSCR_C_S) || (cmd_q == `SSCR_C_A) ||
	                     (cmd_q == `SSCR_C_H) || (cmd_q == `SSCR_C_TMP) || (cmd_q == `SSCR_C_ID) || is_u;
	wire       start_rep = exec_q && rep_cmd;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			p_st_q <= sscr_pkg::PS_IDLE;
			{exec_q, disc_q, aerr_q} <= 3'h0;
			{cmd_q, acnt_q, aval_q, tens_q} <= 35'h0;
		end else begin
			{exec_q, disc_q} <= 2'h0;
			if (rx_cr) begin
				exec_q <= (p_st_q == sscr_pkg::PS_ARG);
				p_st_q <= sscr_pkg::PS_S1;
			end else if (rx_valid_i) begin
				case (p_st_q)
					sscr_pkg::PS_S1: p_st_q <= (rx_data_i == `SSCR_SL) ? sscr_pkg::PS_S2 : sscr_pkg::PS_IDLE;
					sscr_pkg::PS_S2: p_st_q <= (rx_data_i == `SSCR_SL) ? sscr_pkg::PS_DEV : sscr_pkg::PS_IDLE;
					sscr_pkg::PS_DEV: begin
						p_st_q <= (rx_data_i == port_chr(dev)) ? sscr_pkg::PS_CMD : sscr_pkg::PS_SKIP;
						disc_q <= (rx_data_i != port_chr(dev));
					end
					sscr_pkg::PS_CMD: begin
						cmd_q <= rx_data_i;
						acnt_q <= 7'h00;
						aerr_q <= 1'b0;
						p_st_q <= sscr_pkg::PS_ARG;
					end
					sscr_pkg::PS_ARG: begin
						acnt_q <= acnt_q + {6'h00, ~&acnt_q};
						if (!is_dig || acnt_q >= `SSCR_MAX_ARGS) begin
							aerr_q <= 1'b1;
						end else begin
							aval_q <= {aval_q[11:0], rx_data_i[3:0]};
							if (!acnt_q[0]) begin
								tens_q <= rx_data_i[3:0];
							end else if (pv_bad && is_p) begin
								aerr_q <= 1'b1;
							end
						end
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rx_valid_i && p_st_q == sscr_pkg::PS_ARG && acnt_q[0] && !acnt_q[6]) begin
			pbuf_q[acnt_q[5:1]] <= pv7[5:0];
		end
	end

	// pair application, one pair per cycle
	wire       ap_act = ap_i_q != ap_n_q;
	wire [5:0] ap_a   = pbuf_q[{ap_i_q[3:0], 1'b0}];
	wire [5:0] ap_b   = pbuf_q[{ap_i_q[3:0], 1'b1}];
	wire [5:0] old_a  = pend_q[5'(ap_a - 6'h01)];
	wire [5:0] old_b  = pend_q[5'(ap_b - 6'h01)];
	wire       loop   = ctrl_q[`SSCR_B_LOOP];
	for (genvar gi = 0; gi < 32; gi++) begin : g_pend
		localparam logic [5:0] PN = 6'(gi + 1);
		assign pend_d[gi] = !ap_act ? pend_q[gi] :
		                    (PN == ap_a) ? ap_b : (PN == ap_b) ? ap_a :
		                    (PN == old_a || PN == old_b) ? (loop ? PN : 6'h00) : pend_q[gi];
	end

	wire hold_zero = hold_q == 8'h00;
	wire applied   = hold_zero && (act_q != pend_q);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{ap_n_q, ap_i_q} <= 10'h000;
			pend_q <= '0;
			act_q <= '0;
			{hold_q, pre_q} <= 40'h0;
		end else begin
			pend_q <= pend_d;
			if (hold_zero) act_q <= pend_q;
			if (exec_q && is_p && p_ok) begin
				ap_n_q <= acnt_q[6:2];
				ap_i_q <= 5'h00;
			end else if (ap_act) begin
				ap_i_q <= ap_i_q + 5'h01;
			end
			if (exec_q && is_rt) begin
				hold_q <= ctrl_q[15:8];
				pre_q <= 32'h0;
			end else if (exec_q && is_x) begin
				hold_q <= 8'h00;
			end else if (!hold_zero) begin
				pre_q <= (pre_q == TENTH_CYC - 1) ? 32'h0 : pre_q + 32'h1;
				if (pre_q == TENTH_CYC - 1) hold_q <= hold_q - 8'h01;
			end
		end
	end

	// reply generator
	wire [7:0] mag    = temp_v[7] ? 8'(-temp_v) : temp_v;
	wire [3:0] t_hun  = 4'(mag / 8'h64);
	wire [3:0] t_ten  = 4'((mag / 8'h0a) % 8'h0a);
	wire [3:0] t_one  = 4'(mag % 8'h0a);
	wire [7:0] t_chr  = (bidx_q == 5'h00) ? (temp_v[7] ? 8'h2d : 8'h2b) :
	                    {4'h3, (bidx_q == 5'h01) ? t_hun : (bidx_q == 5'h02) ? t_ten : t_one};
	logic [7:0] body_c;
	logic [4:0] body_n;
	always_comb begin
		body_c = 8'h30;
		body_n = 5'h01;
		case (rcmd_q)
			`SSCR_C_R:   begin body_c = REV_STR[8*(REV_LEN-1-int'(bidx_q)) +: 8]; body_n = 5'(REV_LEN); end
			`SSCR_C_ID:  begin body_c = ID_STR[8*(ID_LEN-1-int'(bidx_q)) +: 8]; body_n = 5'(ID_LEN); end
			`SSCR_C_A:   begin body_c = hex_chr(bidx_q[0] ? stat_q[3:0] : stat_q[7:4]); body_n = 5'h02; end
			`SSCR_C_H:   begin body_c = hex_chr(bidx_q[0] ? ctrl_q[11:8] : ctrl_q[15:12]); body_n = 5'h02; end
			`SSCR_C_TMP: begin body_c = t_chr; body_n = 5'h04; end
			default:     body_c = {7'h18, ulk_q};
		endcase
	end

	wire       tx_ld    = !txv_q || tx_ready_i;
	wire [5:0] scan_prt = {1'b0, scan_q} + 6'h01;
	wire [5:0] scan_par = act_q[scan_q];
	wire       scan_hit = scan_par > scan_prt;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_st_q <= sscr_pkg::TS_IDLE;
			{txv_q, half_q, ulk_q} <= 3'h0;
			{tx_q, rcmd_q} <= 16'h0000;
			{hidx_q, bidx_q, scan_q} <= 12'h000;
		end else if (tx_ld) begin
			txv_q <= 1'b1;
			case (tx_st_q)
				sscr_pkg::TS_IDLE: begin
					txv_q <= 1'b0;
					if (start_rep) begin
						tx_st_q <= sscr_pkg::TS_HEAD;
						rcmd_q <= cmd_q;
						ulk_q <= pw_ok;
						{hidx_q, bidx_q, scan_q, half_q} <= 13'h0000;
					end
				end
				sscr_pkg::TS_HEAD: begin
					tx_q <= (hidx_q == 2'h2) ? port_chr(dev) : (hidx_q == 2'h3) ? rcmd_q : `SSCR_SL;
					hidx_q <= hidx_q + 2'h1;
					if (hidx_q == 2'h3) tx_st_q <= (rcmd_q == `SSCR_C_S) ? sscr_pkg::TS_SCAN : sscr_pkg::TS_BODY;
				end
				sscr_pkg::TS_BODY: begin
					tx_q <= body_c;
					bidx_q <= bidx_q + 5'h01;
					if (bidx_q == body_n - 5'h01) tx_st_q <= sscr_pkg::TS_CR;
				end
				sscr_pkg::TS_SCAN: begin
					txv_q <= scan_hit;
					tx_q <= port_chr(half_q ? scan_par : scan_prt);
					half_q <= scan_hit && !half_q;
					if (!scan_hit || half_q) begin
						scan_q <= scan_q + 5'h01;
						if (&scan_q) tx_st_q <= sscr_pkg::TS_CR;
					end
				end
				sscr_pkg::TS_CR: begin
					tx_q <= `SSCR_CR;
					tx_st_q <= sscr_pkg::TS_IDLE;
				end
				default: tx_st_q <= sscr_pkg::TS_IDLE;
			endcase
		end
	end

	// apb registers
	wire       acc     = psel_i && penable_i && !pready_q;
	wire       wr      = psel_i && penable_i && pready_q && pwrite_i;
	wire       temp_ov = $signed(temp_v) > $signed({1'b0, cfg_q[23:16]});
	wire [4:0] ev      = {applied, disc_q, exec_q && is_u && !pw_ok, exec_q && is_u && pw_ok, exec_q};
	wire       hit     = (paddr_i == `SSCR_A_CTRL) || (paddr_i == `SSCR_A_CFG) || (paddr_i == `SSCR_A_STAT) ||
	                     (paddr_i == `SSCR_A_IRQ) || (paddr_i == `SSCR_A_MASK);
	wire [31:0] rdata  = (paddr_i == `SSCR_A_CTRL) ? ctrl_q : (paddr_i == `SSCR_A_CFG) ? cfg_q :
	                     (paddr_i == `SSCR_A_STAT) ? {15'h0, tx_st_q != sscr_pkg::TS_IDLE, hold_q, stat_q} :
	                     (paddr_i == `SSCR_A_IRQ) ? {27'h0, ist_q} : (paddr_i == `SSCR_A_MASK) ? {27'h0, mask_q} : 32'h0;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= `SSCR_CTRL_RST;
			cfg_q <= `SSCR_CFG_RST;
			{ist_q, mask_q} <= 10'h000;
			{pready_q, perr_q, irq_q} <= 3'h0;
			{prdata_q, stat_q} <= 40'h0;
		end else begin
			pready_q <= acc;
			perr_q <= acc && !hit;
			if (acc) prdata_q <= rdata;
			if (wr && paddr_i == `SSCR_A_CTRL) ctrl_q <= pwdata_i & 32'h1f00_ff3f;
			if (exec_q && is_u && pw_ok) ctrl_q[`SSCR_B_PANEL] <= 1'b0;
			if (wr && paddr_i == `SSCR_A_CFG) cfg_q <= pwdata_i & 32'h00ff_ffff;
			if (wr && paddr_i == `SSCR_A_MASK) mask_q <= pwdata_i[4:0];
			ist_q <= (ist_q & ~((wr && paddr_i == `SSCR_A_IRQ) ? pwdata_i[4:0] : 5'h00)) | ev;
			irq_q <= |(ist_q & mask_q);
			stat_q <= {ctrl_q[28:`SSCR_B_LAN], temp_ov, psu2_s, psu1_s};
		end
	end

	assign prdata_o   = prdata_q;
	assign pready_o   = pready_q;
	assign pslverr_o  = perr_q;
	assign tx_valid_o = txv_q;
	assign tx_data_o  = tx_q;
	assign map_o      = act_q;
	assign irq_o      = irq_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_cr_seen; rx_valid_i && rx_data_i == `SSCR_CR; endsequence
	sequence s_x_cmd; exec_q && is_x; endsequence
	chk_pair_write:
		assert property (ap_act |=> pend_q[5'($past(ap_a) - 6'h01)] == $past(ap_b)) else $error("pair not patched");
	chk_reply_end:
		assert property (tx_st_q == sscr_pkg::TS_CR && tx_ld |=> tx_valid_o && tx_data_o == `SSCR_CR)
			else $error("reply not closed by cr");
	chk_hold_restart:
		assert property (exec_q && is_rt |=> hold_q == $past(ctrl_q[15:8])) else $error("holdoff not restarted");
	chk_unlock_clear:
		assert property (exec_q && is_u && pw_ok |=> !ctrl_q[`SSCR_B_PANEL] ##1 1'b1) else $error("panel still locked");
	chk_clear_apply:
		assert property (s_x_cmd |=> hold_zero ##1 act_q == $past(pend_q)) else $error("pending map not applied");
	chk_alarm_byte:
		assert property (stat_q[2:0] == $past({temp_ov, psu2_s, psu1_s})) else $error("alarm bits wrong");
	chk_mode_bits:
		assert property (stat_q[7:3] == $past(ctrl_q[28:24])) else $error("mode bits wrong");
	chk_hold_tick:
		assert property (!hold_zero && pre_q == TENTH_CYC - 1 && !exec_q |=> hold_q == $past(hold_q) - 8'h01)
			else $error("holdoff step wrong");
	chk_dev_reject:
		assert property (p_st_q == sscr_pkg::PS_DEV && rx_valid_i && !rx_cr && rx_data_i != port_chr(dev)
			|=> p_st_q == sscr_pkg::PS_SKIP && disc_q) else $error("foreign command not discarded");
	chk_reply_after:
		assert property (s_cr_seen ##1 (start_rep && tx_st_q == sscr_pkg::TS_IDLE && tx_ld)
			|=> tx_st_q == sscr_pkg::TS_HEAD) else $error("reply not started after cr");
endmodule
`default_nettype wire

/* verification/sscr_host.sv */
// host side model: sends command frames and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module sscr_host (
	// clock
	input  wire logic       clk_i,
	// command bytes to the responder
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	// reply bytes from the responder
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	// stall control
	input  wire logic       slow_i
);
	byte unsigned rq[$];
	logic         ph_q = 1'b0;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
	end
	// accept only every other edge when slow
	assign tx_ready_o = !slow_i || ph_q;
	always @(posedge clk_i) begin
		ph_q <= !ph_q;
		if (tx_valid_i && tx_ready_o)
			rq.push_back(tx_data_i);
	end
	// frames open with cr slash slash and close with cr
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o  <= s[i];
		end
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		// stale byte must not look valid
		rx_data_o  <= ~rx_data_o;
	endtask
endmodule
`default_nettype wire

/* verification/sscr_top_test.sv */
// self-checking bench of the command responder
`timescale 1ns/1ps
`default_nettype none
`include "sscr_map.svh"
module sscr_top_test;
	logic         clk_i       = 1'b0;
	logic         rst_b_i     = 1'b0;
	logic         psel_i      = 1'b0;
	logic         penable_i   = 1'b0;
	logic         pwrite_i    = 1'b0;
	logic [7:0]   paddr_i     = 8'h00;
	logic [31:0]  pwdata_i    = 32'h0;
	logic         psu1_fail_i = 1'b0;
	logic         psu2_fail_i = 1'b0;
	logic [7:0]   temp_i      = 8'h1c;
	logic         slow        = 1'b0;
	logic [31:0]  prdata_o;
	logic         pready_o;
	logic         pslverr_o;
	logic         rx_valid_i;
	logic [7:0]   rx_data_i;
	logic         tx_ready_i;
	logic         tx_valid_o;
	logic [7:0]   tx_data_o;
	logic [191:0] map_o;
	logic         irq_o;
	logic [31:0]  rd;
	logic         err;
	int           fails           = 0;
	int           samples_checked = 0;
	always #4 clk_i = ~clk_i;
	sscr_top #(.TENTH_CYC(4)) dut_u (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_ready_i(tx_ready_i),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .psu1_fail_i(psu1_fail_i),
		.psu2_fail_i(psu2_fail_i), .temp_i(temp_i), .map_o(map_o), .irq_o(irq_o));
	sscr_host host_u (
		.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .slow_i(slow));
	task automatic print_verdict();
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_s(input string g, input string e);
		samples_checked++;
		if (g != e) begin
			fails++;
			$display("ERROR %0t reply %s expected %s", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// send a frame, collect the whole reply plus a quiet tail
	task automatic reply(input string c, input string e);
		string g;
		g = "";
		host_u.send(c);
		for (int i = 0; i < 400 && host_u.rq.size() < e.len(); i++)
			@(posedge clk_i);
		repeat (20) @(posedge clk_i);
		while (host_u.rq.size() > 0)
			g = $sformatf("%s%c", g, host_u.rq.pop_front());
		chk_s(g, e);
	endtask
	function automatic string pc(input int n);
		return $sformatf("%c", n <= 4 ? 8'h7b + n : 8'h5b + n);
	endfunction
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
	initial begin
		string s;
		string e;
		s = "\r//|P";
		e = "//|S";
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		apb(1'b0, `SSCR_A_CTRL, 32'h0);
		chk(rd, `SSCR_CTRL_RST);
		apb(1'b0, `SSCR_A_CFG, 32'h0);
		chk(rd, `SSCR_CFG_RST);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		chk(err, 32'h1);
		psu1_fail_i <= 1'b1;
		psu2_fail_i <= 1'b1;
		temp_i      <= 8'h3c;
		apb(1'b1, `SSCR_A_CTRL, 32'h1f00_0001);
		reply("\r//|a\r", "//|aFF\r");
		apb(1'b0, `SSCR_A_STAT, 32'h0);
		chk(rd, 32'h0000_00ff);
		psu2_fail_i <= 1'b0;
		temp_i      <= 8'h32;
		apb(1'b1, `SSCR_A_CTRL, 32'h0a00_0001);
		reply("\r//|a\r", "//|a51\r");
		psu1_fail_i <= 1'b0;
		psu2_fail_i <= 1'b1;
		temp_i      <= 8'h33;
		apb(1'b1, `SSCR_A_CTRL, 32'h1500_0001);
		reply("\r//|a\r", "//|aAE\r");
		temp_i <= 8'h1c;
		reply("\r//|t\r", "//|t+028\r");
		temp_i <= 8'hfb;
		reply("\r//|t\r", "//|t-005\r");
		reply("\r//|R\r", "//|R0100\r");
		reply("\r//|?\r", "//|?PSW-32  0000001 01/01/00\r");
		apb(1'b1, `SSCR_A_CTRL, 32'h0000_2001);
		reply("\r//|h\r", "//|h20\r");
		reply("\r//|W\r", "");
		reply("\r//|P0708\r", "");
		chk(map_o[41:36], 32'h0);
		repeat (150) @(posedge clk_i);
		chk(map_o[41:36], 32'h8);
		reply("\r//|T\r", "");
		reply("\r//|P0910\r", "");
		chk(map_o[53:48], 32'h0);
		reply("\r//|X\r", "");
		chk(map_o[53:48], 32'ha);
		apb(1'b1, `SSCR_A_CTRL, 32'h1);
		for (int k = 1; k <= 16; k++) begin
			s = {s, $sformatf("%02d%02d", k, 33 - k)};
			e = {e, pc(k), pc(33 - k)};
		end
		reply({s, "\r"}, "");
		for (int k = 1; k <= 16; k++) begin
			chk(map_o[6*k-6 +: 6], 33 - k);
			chk(map_o[192-6*k +: 6], k);
		end
		slow <= 1'b1;
		reply("\r//|S\r", {e, "\r"});
		slow <= 1'b0;
		reply("\r//|P0102\r", "");
		chk(map_o[11:0], {20'h0, 6'h01, 6'h02});
		chk(map_o[191:180], 32'h0);
		apb(1'b1, `SSCR_A_CTRL, 32'h1000_0001);
		reply("\r//|P0304\r", "");
		chk(map_o[179:168], {20'h0, 6'h1e, 6'h1d});
		apb(1'b1, `SSCR_A_CFG, 32'h0032_1234);
		apb(1'b1, `SSCR_A_CTRL, 32'h0200_0001);
		reply("\r//|U1235\r", "//|U0\r");
		reply("\r//|U12\r", "//|U0\r");
		apb(1'b0, `SSCR_A_CTRL, 32'h0);
		chk(rd, 32'h0200_0001);
		reply("\r//|U1234\r", "//|U1\r");
		apb(1'b0, `SSCR_A_CTRL, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, `SSCR_A_IRQ, 32'h1f);
		apb(1'b1, `SSCR_A_MASK, 32'h8);
		reply("\r/x|a\r", "");
		reply("\r//}a\r", "");
		chk(irq_o, 32'h1);
		apb(1'b0, `SSCR_A_IRQ, 32'h0);
		chk(rd, 32'h8);
		apb(1'b1, `SSCR_A_MASK, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 32'h0);
		apb(1'b1, `SSCR_A_MASK, 32'h8);
		apb(1'b1, `SSCR_A_IRQ, 32'h8);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 32'h0);
		host_u.send("\r//|h");
		repeat (20) @(posedge clk_i);
		chk(host_u.rq.size(), 32'h0);
		reply("\r", "//|h00\r");
		print_verdict();
	end
endmodule
`default_nettype wire
